/* hdl/sbcg_flag_array.sv */
`timescale 1ns/1ps

module sbcg_flag_array
  import sbcg_pkg::*;
#(
  parameter int BITS = FLAG_BITS,
  parameter int AW = 10
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [AW-1:0] idx,
  input wire logic wrBit,
  output logic rdBit
);

  // Each flag is its own storage bit, so single-bit set, clear and test work.
  logic [BITS-1:0] flags_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else if (wrEn) begin
      flags_q[idx] <= wrBit;
    end
  end

  assign rdBit = flags_q[idx];

endmodule : sbcg_flag_array

/* hdl/sbcg_glue.sv */
`timescale 1ns/1ps

// Contract
// - Derive a 2.5 MHz system clock from the 10 MHz processor clock; the glue divides it from the core clock instead.
// - Hold processor reset during power-on and while power-ready reset is low.
// - Assert the I/O reset whenever the processor is held in reset.
// - Select on-board RAM for memory addresses 3800 through 3FFF.
// - On-board RAM cycles complete with no wait states.
// - Select program ROM for memory addresses 0 through 1FFF.
// - Decode 1K-bit flag array at bit-serial addresses 800 through FFE.
// - Every flag bit responds alone to set, clear, test and multi-bit moves.
// - Power fail level 1, clock level 3, backplane common level 4.
// - Four maskable static level requests plus two non-maskable interrupts; the glue passes one NMI line, nmiInN.
// - A priority encoder gives a 3-bit code to the processor.
// - End of analog conversion raises a level 2 request.
// - Backplane carries only bit-serial I/O, never memory transfers.
// - Drive backplane A0-A14, strobe, serial out, memory cycle, I/O reset, clock.
// - Hold backplane busy line low permanently.
// - A jumper option disables every backplane driver.
// - Sixteen digital inputs and outputs sit as bits in bit-serial space.
// - With the option fitted, an input bit shows power-failure status.
// - Bit-serial link has separate input, output and strobe lines.
module sbcg_glue
  import sbcg_pkg::*;
#(
  parameter int POR_CNT = POR_CYCLES,
  parameter int NDIO = DIO_BITS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Processor side.
  output logic cpuClk,
  output logic cpuResetN,
  output logic cpuNmiN,
  output logic [2:0] interruptCodeBits,
  input wire logic [15:0] cpuMemAddr,
  input wire logic cpuMemCycleN,
  output logic romSelN,
  output logic ramSelN,
  output logic memReady,
  input wire logic [14:0] cpuIoAddr,
  input wire logic cpuIoStrobe,
  input wire logic cpuIoOut,
  output logic cpuIoIn,
  // Interrupt sources.
  input wire logic nmiInN,
  input wire logic powerLossFlag,
  input wire logic adcEndOfConv,
  input wire logic clockIrq,
  input wire logic backplaneCommonIrqN,
  // Digital ports.
  input wire logic [NDIO-1:0] digitalIn,
  output logic [NDIO-1:0] digitalOut,
  // Backplane.
  input wire logic powerReadyResetN,
  input wire logic serialIoIn,
  output logic backplaneDriveEn,
  output logic [14:0] backplaneAddr,
  output logic serialIoStrobe,
  output logic serialIoOut,
  output logic memoryCycleN,
  output logic ioResetOut,
  output logic backplaneSyncClock,
  output logic busyOut,
  output logic busyOe
);

  sbcg_rst_state_t rstState_q;
  sbcg_rst_state_t rstState_d;
  logic [POR_W-1:0] porCnt_q;
  logic [DIV_W-1:0] cpuDiv_q;
  logic [DIV_W-1:0] sysDiv_q;
  logic [1:0] ctrl_q;
  logic [NDIO-1:0] dout_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic inReset;
  logic [4:1] irqReq;
  logic [2:0] irqCode;
  logic addrPhase;
  logic [31:0] rdMux;
  logic isFlag;
  logic isDio;
  logic isPf;
  logic isExt;
  logic flagRd;
  logic flagWr;
  logic [3:0] dioIdx;
  logic bpOn;
  logic pfOn;

  assign bpOn = !ctrl_q[CTRL_BP_OFF_BIT];
  assign pfOn = ctrl_q[CTRL_PF_PORT_BIT];

  // Reset sequencer. Leaving a backplane reset restarts the power-on count, so
  // a short pulse on the power-ready line still gives a full-length reset.
  always_comb begin
    rstState_d = rstState_q;
    case (rstState_q)
      SBCG_POR: begin
        if (!powerReadyResetN) begin
          rstState_d = SBCG_BPRST;
        end else if (porCnt_q == POR_W'(POR_CNT - 1)) begin
          rstState_d = SBCG_RUN;
        end
      end
      SBCG_RUN: begin
        if (!powerReadyResetN) begin
          rstState_d = SBCG_BPRST;
        end
      end
      SBCG_BPRST: begin
        if (powerReadyResetN) begin
          rstState_d = SBCG_POR;
        end
      end
      default: begin
        rstState_d = SBCG_POR;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstState_q <= SBCG_POR;
    end else begin
      rstState_q <= rstState_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      porCnt_q <= '0;
    end else if (rstState_q == SBCG_POR) begin
      porCnt_q <= porCnt_q + POR_W'(1);
    end else begin
      porCnt_q <= '0;
    end
  end

  assign inReset = (rstState_d != SBCG_RUN);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuResetN <= 1'b0;
      ioResetOut <= 1'b1;
    end else begin
      cpuResetN <= !inReset;
      ioResetOut <= inReset;
    end
  end

  // Clock dividers: the processor clock and the system clock, each divided from the core clock.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuDiv_q <= '0;
      cpuClk <= 1'b0;
    end else if (cpuDiv_q == DIV_W'(CPU_HALF_CYCLES - 1)) begin
      cpuDiv_q <= '0;
      cpuClk <= !cpuClk;
    end else begin
      cpuDiv_q <= cpuDiv_q + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sysDiv_q <= '0;
      backplaneSyncClock <= 1'b0;
    end else if (sysDiv_q == DIV_W'(SYS_HALF_CYCLES - 1)) begin
      sysDiv_q <= '0;
      backplaneSyncClock <= !backplaneSyncClock;
    end else begin
      sysDiv_q <= sysDiv_q + DIV_W'(1);
    end
  end

  // Interrupts are static levels; the encoder simply follows them.
  assign irqReq[LVL_PWR] = powerLossFlag;
  assign irqReq[LVL_ADC] = adcEndOfConv;
  assign irqReq[LVL_CLK] = clockIrq;
  assign irqReq[LVL_BP] = !backplaneCommonIrqN;

  always_comb begin
    irqCode = INT_CODE_IDLE;
    for (int i = 4; i >= 1; i--) begin
      if (irqReq[i]) begin
        irqCode = 3'(i);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      interruptCodeBits <= INT_CODE_IDLE;
      cpuNmiN <= 1'b1;
    end else begin
      interruptCodeBits <= irqCode;
      cpuNmiN <= nmiInN;
    end
  end

  // Memory decode. Registered selects trade one cycle of latency for clean
  // chip selects; the RAM still answers with ready held high throughout.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      romSelN <= 1'b1;
      ramSelN <= 1'b1;
      memReady <= 1'b1;
    end else begin
      romSelN <= !(!cpuMemCycleN && cpuMemAddr <= ROM_HI);
      ramSelN <= !(!cpuMemCycleN && cpuMemAddr >= RAM_LO
                   && cpuMemAddr <= RAM_HI);
      memReady <= 1'b1;
    end
  end

  // Bit-serial space decode.
  assign isFlag = cpuIoAddr >= FLAG_LO && cpuIoAddr <= FLAG_HI;
  assign isDio = cpuIoAddr >= DIO_LO && cpuIoAddr <= DIO_HI;
  assign isPf = pfOn && cpuIoAddr == PF_ADDR;
  assign isExt = !isFlag && !isDio && !isPf;
  assign dioIdx = cpuIoAddr[4:1];
  assign flagWr = cpuIoStrobe && isFlag;

  sbcg_flag_array #(
    .BITS(FLAG_BITS),
    .AW(10)
  ) u_flags (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(flagWr),
    .idx(cpuIoAddr[10:1]),
    .wrBit(cpuIoOut),
    .rdBit(flagRd)
  );

  // The output latches return to zero under I/O reset, like any other
  // circuit attached to that line.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_q <= '0;
    end else if (ioResetOut) begin
      dout_q <= '0;
    end else if (cpuIoStrobe && isDio) begin
      dout_q[dioIdx] <= cpuIoOut;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      digitalOut <= '0;
      cpuIoIn <= 1'b0;
    end else begin
      digitalOut <= dout_q;
      if (isFlag) begin
        cpuIoIn <= flagRd;
      end else if (isDio) begin
        cpuIoIn <= digitalIn[dioIdx];
      end else if (isPf) begin
        cpuIoIn <= powerLossFlag;
      end else begin
        cpuIoIn <= bpOn & serialIoIn;
      end
    end
  end

  // Backplane drivers. Memory cycles never leave the board, so the memory
  // cycle line stays inactive and the busy line stays low.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      backplaneDriveEn <= 1'b0;
      backplaneAddr <= '0;
      serialIoStrobe <= 1'b0;
      serialIoOut <= 1'b0;
      memoryCycleN <= 1'b1;
      busyOut <= 1'b0;
      busyOe <= 1'b0;
    end else begin
      backplaneDriveEn <= bpOn;
      backplaneAddr <= cpuIoAddr;
      serialIoStrobe <= bpOn && cpuIoStrobe && isExt;
      serialIoOut <= cpuIoOut;
      memoryCycleN <= 1'b1;
      busyOut <= 1'b0;
      busyOe <= bpOn;
    end
  end

  // Register bus slave: always ready, always OKAY.
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;

  always_comb begin
    rdMux = '0;
    case (haddr[7:0])
      REG_CTRL: rdMux = {30'h0, ctrl_q};
      REG_STATUS: rdMux = {23'h0, bpOn, irqReq, interruptCodeBits, !cpuResetN};
      REG_DIN: rdMux = 32'(digitalIn);
      REG_DOUT: rdMux = 32'(dout_q);
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPhase && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrPend_q && wrAddr_q == REG_CTRL) begin
      ctrl_q <= hwdata[1:0];
    end
  end

endmodule : sbcg_glue

/* hdl/sbcg_pkg.sv */
package sbcg_pkg;

  // Clocking: core clock, processor input clock and the derived system clock.
  localparam int CORE_CLK_KHZ = 200000;
  localparam int CPU_CLK_KHZ = 10000;
  localparam int SYS_CLK_KHZ = 2500;
  localparam int CPU_HALF_CYCLES = CORE_CLK_KHZ / (2 * CPU_CLK_KHZ);
  localparam int SYS_HALF_CYCLES = CORE_CLK_KHZ / (2 * SYS_CLK_KHZ);
  localparam int DIV_W = 8;

  // Power-on reset hold time.
  localparam int POR_TIME_US = 10;
  localparam int POR_CYCLES = (POR_TIME_US * CORE_CLK_KHZ) / 1000;
  localparam int POR_W = 16;

  // Memory map.
  localparam logic [15:0] ROM_LO = 16'h0000;
  localparam logic [15:0] ROM_HI = 16'h1fff;
  localparam logic [15:0] RAM_LO = 16'h3800;
  localparam logic [15:0] RAM_HI = 16'h3fff;

  // Bit-serial I/O space, addresses as held in the base register.
  localparam logic [14:0] FLAG_LO = 15'h0800;
  localparam logic [14:0] FLAG_HI = 15'h0ffe;
  localparam int FLAG_BITS = 1024;
  localparam logic [14:0] DIO_LO = 15'h1000;
  localparam logic [14:0] DIO_HI = 15'h101e;
  localparam logic [14:0] PF_ADDR = 15'h1020;
  localparam int DIO_BITS = 16;

  // Interrupt levels and the code shown when nothing is pending.
  localparam logic [2:0] LVL_PWR = 3'h1;
  localparam logic [2:0] LVL_ADC = 3'h2;
  localparam logic [2:0] LVL_CLK = 3'h3;
  localparam logic [2:0] LVL_BP = 3'h4;
  localparam logic [2:0] INT_CODE_IDLE = 3'h7;

  // Register map, byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DIN = 8'h08;
  localparam logic [7:0] REG_DOUT = 8'h0c;
  localparam int CTRL_BP_OFF_BIT = 0;
  localparam int CTRL_PF_PORT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    SBCG_POR = 3'b001,
    SBCG_RUN = 3'b010,
    SBCG_BPRST = 3'b100
  } sbcg_rst_state_t;

endpackage : sbcg_pkg

/* verif/sbcg_checker.sv */
`timescale 1ns/1ps

module sbcg_checker
  import sbcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] cpuMemAddr,
  input wire logic cpuMemCycleN,
  input wire logic romSelN,
  input wire logic ramSelN,
  input wire logic memReady,
  input wire logic cpuResetN,
  input wire logic ioResetOut,
  input wire logic powerReadyResetN,
  input wire logic powerLossFlag,
  input wire logic [2:0] interruptCodeBits,
  input wire logic cpuClk,
  input wire logic backplaneSyncClock,
  input wire logic cpuIoStrobe,
  input wire logic [14:0] cpuIoAddr,
  input wire logic serialIoStrobe,
  input wire logic [14:0] backplaneAddr,
  input wire logic backplaneDriveEn,
  input wire logic memoryCycleN,
  input wire logic busyOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  ram_select_a: assert property (
    !cpuMemCycleN && cpuMemAddr >= RAM_LO && cpuMemAddr <= RAM_HI
    |=> !ramSelN && romSelN && memReady) else $error("RAM select wrong");
  rom_select_a: assert property (
    !cpuMemCycleN && cpuMemAddr <= ROM_HI |=> !romSelN && ramSelN) else $error("ROM select wrong");
  no_select_a: assert property (
    cpuMemCycleN || (cpuMemAddr > ROM_HI && cpuMemAddr < RAM_LO) || cpuMemAddr > RAM_HI
    |=> romSelN && ramSelN) else $error("stray memory select");
  ready_reset_a: assert property (
    !powerReadyResetN |-> ##[1:2] !cpuResetN) else $error("reset not taken");
  io_reset_a: assert property (
    !cpuResetN |-> ioResetOut) else $error("I/O reset missing");
  pwr_prio_a: assert property (
    powerLossFlag |=> interruptCodeBits == LVL_PWR) else $error("power level wrong");
  cpu_clk_a: assert property (
    $changed(cpuClk) |-> ##10 $changed(cpuClk)) else $error("processor clock period");
  sync_clk_a: assert property (
    $changed(backplaneSyncClock) |-> ##40 $changed(backplaneSyncClock))
    else $error("system clock period");
  strobe_copy_a: assert property (
    serialIoStrobe |-> backplaneDriveEn && $past(cpuIoStrobe)
    && backplaneAddr == $past(cpuIoAddr)) else $error("backplane strobe wrong");
  bus_idle_a: assert property (
    !busyOut && memoryCycleN) else $error("busy or memory cycle driven");
endmodule : sbcg_checker

bind sbcg_glue sbcg_checker u_chk (.core_clk, .rst_b, .cpuMemAddr, .cpuMemCycleN, .romSelN,
  .ramSelN, .memReady, .cpuResetN, .ioResetOut, .powerReadyResetN, .powerLossFlag,
  .interruptCodeBits, .cpuClk, .backplaneSyncClock, .cpuIoStrobe, .cpuIoAddr,
  .serialIoStrobe, .backplaneAddr, .backplaneDriveEn, .memoryCycleN, .busyOut);

/* verif/sbcg_ioexp_model.sv */
`timescale 1ns/1ps

module sbcg_ioexp_model #(
  parameter logic [14:0] BASE = 15'h2000
) (
  input wire logic core_clk,
  input wire logic driveEn,
  input wire logic ioReset,
  input wire logic strobe,
  input wire logic [14:0] addr,
  input wire logic dout,
  output logic din
);
  logic [15:0] bits_q = 16'h0000;
  logic tgl_q = 1'b0;
  logic hit;
  // An unselected line shows a changing pattern, so a stale bit cannot pass.
  assign hit = driveEn && addr[14:5] == BASE[14:5];
  assign din = hit ? bits_q[addr[4:1]] : tgl_q;
  always_ff @(posedge core_clk) begin
    tgl_q <= !tgl_q;
    if (ioReset) begin
      bits_q <= 16'h0000;
    end else if (hit && strobe) begin
      bits_q[addr[4:1]] <= dout;
    end
  end
endmodule : sbcg_ioexp_model

/* verif/tb.sv */
`timescale 1ns/1ps

module tb;
  import sbcg_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, interruptCodeBits;
  logic [15:0] cpuMemAddr = 16'h0, digitalIn = 16'h0, digitalOut;
  logic [14:0] cpuIoAddr = 15'h0, backplaneAddr;
  logic cpuMemCycleN = 1'b1, cpuIoStrobe = 1'b0, cpuIoOut = 1'b0, nmiInN = 1'b1;
  logic powerLossFlag = 1'b0, adcEndOfConv = 1'b0, clockIrq = 1'b0;
  logic backplaneCommonIrqN = 1'b1, powerReadyResetN = 1'b1;
  logic hreadyout, hresp, cpuClk, cpuResetN, cpuNmiN, romSelN, ramSelN, memReady, cpuIoIn;
  logic backplaneDriveEn, serialIoStrobe, serialIoOut, memoryCycleN, ioResetOut;
  logic backplaneSyncClock, busyOut, busyOe, serialIoIn;
  logic [15:0] memTab [7] = '{16'h0, 16'h1fff, 16'h2000, 16'h37ff, 16'h3800, 16'h3fff, 16'h4000};
  int err_count = 0, n_tests = 0;
  logic [2:0] expCode;

  always #2.5 core_clk = ~core_clk;

  sbcg_glue #(.POR_CNT(20)) i_dut (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpuClk, .cpuResetN, .cpuNmiN,
    .interruptCodeBits, .cpuMemAddr, .cpuMemCycleN, .romSelN, .ramSelN, .memReady, .cpuIoAddr,
    .cpuIoStrobe, .cpuIoOut, .cpuIoIn, .nmiInN, .powerLossFlag, .adcEndOfConv, .clockIrq,
    .backplaneCommonIrqN, .digitalIn, .digitalOut, .powerReadyResetN, .serialIoIn,
    .backplaneDriveEn, .backplaneAddr, .serialIoStrobe, .serialIoOut, .memoryCycleN,
    .ioResetOut, .backplaneSyncClock, .busyOut, .busyOe);

  sbcg_ioexp_model i_exp (.core_clk, .driveEn(backplaneDriveEn), .ioReset(ioResetOut),
    .strobe(serialIoStrobe), .addr(backplaneAddr), .dout(serialIoOut), .din(serialIoIn));

  task give_verdict;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        err_count++;
        give_verdict;
      end
      if (k == 0) begin
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    d = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb

  task io_wr(input logic [14:0] a, input logic b);
    @(posedge core_clk);
    cpuIoAddr <= a;
    cpuIoOut <= b;
    cpuIoStrobe <= 1'b1;
    @(posedge core_clk);
    cpuIoStrobe <= 1'b0;
  endtask : io_wr

  task io_rd(input logic [14:0] a, input logic exp);
    @(posedge core_clk);
    cpuIoAddr <= a;
    repeat (3) @(posedge core_clk);
    #1;
    chk(cpuIoIn, exp);
  endtask : io_rd

  task wait_run;
    int n;
    for (n = 0; n < 100 && cpuResetN !== 1'b1; n++) @(posedge core_clk);
    if (n >= 100) begin
      err_count++;
      give_verdict;
    end
  endtask : wait_run

  initial begin
    repeat (3) @(posedge core_clk);
    chk({cpuResetN, ioResetOut}, 2'h1);
    rst_b <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    chk(cpuResetN, 1'b0);
    wait_run;
    ahb(1'b0, REG_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      cpuMemAddr <= memTab[i];
      cpuMemCycleN <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(romSelN, memTab[i] > ROM_HI);
      chk(ramSelN, !(memTab[i] >= RAM_LO && memTab[i] <= RAM_HI));
      chk(memReady, 1'b1);
    end
    @(posedge core_clk);
    cpuMemCycleN <= 1'b1;
    cpuMemAddr <= 16'h0;
    @(posedge core_clk);
    #1;
    chk({romSelN, ramSelN}, 2'h3);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      {powerLossFlag, adcEndOfConv, clockIrq} <= i[2:0];
      backplaneCommonIrqN <= !i[3];
      @(posedge core_clk);
      #1;
      expCode = i[2] ? LVL_PWR : i[1] ? LVL_ADC : i[0] ? LVL_CLK : i[3] ? LVL_BP : INT_CODE_IDLE;
      chk(interruptCodeBits, expCode);
    end
    @(posedge core_clk);
    {powerLossFlag, adcEndOfConv, clockIrq, backplaneCommonIrqN, nmiInN} <= 5'h02;
    repeat (2) @(posedge core_clk);
    #1;
    chk(cpuNmiN, 1'b0);
    @(posedge core_clk);
    nmiInN <= 1'b1;
    io_wr(FLAG_LO, 1'b1);
    io_wr(FLAG_HI, 1'b1);
    io_wr(FLAG_LO + 15'h2, 1'b1);
    io_wr(FLAG_LO + 15'h2, 1'b0);
    io_rd(FLAG_LO, 1'b1);
    io_rd(FLAG_HI, 1'b1);
    io_rd(FLAG_LO + 15'h2, 1'b0);
    io_wr(DIO_LO + 15'h6, 1'b1);
    digitalIn <= 16'ha5c3;
    repeat (2) @(posedge core_clk);
    #1;
    chk(digitalOut, 16'h0008);
    ahb(1'b0, REG_DOUT, 32'h0, rd);
    chk(rd, 32'h00000008);
    io_rd(DIO_LO, 1'b1);
    io_rd(DIO_LO + 15'h4, 1'b0);
    ahb(1'b0, REG_DIN, 32'h0, rd);
    chk(rd, 32'h0000a5c3);
    ahb(1'b1, REG_CTRL, 32'h2, rd);
    @(posedge core_clk);
    powerLossFlag <= 1'b1;
    io_rd(PF_ADDR, 1'b1);
    @(posedge core_clk);
    powerLossFlag <= 1'b0;
    io_rd(PF_ADDR, 1'b0);
    chk({backplaneDriveEn, busyOut, busyOe}, 3'h5);
    io_wr(15'h2004, 1'b1);
    io_wr(15'h2006, 1'b0);
    io_rd(15'h2004, 1'b1);
    io_rd(15'h2006, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    io_wr(15'h2004, 1'b0);
    io_rd(15'h2004, 1'b0);
    chk(backplaneDriveEn, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, {23'h0, 1'b0, 4'h0, INT_CODE_IDLE, 1'b0});
    ahb(1'b1, REG_CTRL, 32'h0, rd);
    io_rd(15'h2004, 1'b1);
    @(posedge core_clk);
    powerReadyResetN <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk({cpuResetN, ioResetOut, digitalOut}, 18'h10000);
    @(posedge core_clk);
    powerReadyResetN <= 1'b1;
    wait_run;
    io_rd(15'h2004, 1'b0);
    give_verdict;
  end
endmodule : tb
